// ===== rtl/mas_pkg.sv
// Purpose: Shared constants, step codes and carriers of the auto-setup block.
// Assumes: One 40 MHz clock; object access arrives as decoded messages.
// Notes:   Offsets, step and field codes, bit positions and RTL timing counts live here; MIN_RUN sits in the assertions.

package mas_pkg;

	// ==========================================================
	// Object indices
	localparam logic [15:0] IDX_POLE     = 16'h2030;
	localparam logic [15:0] IDX_CURR     = 16'h2031;
	localparam logic [15:0] IDX_PEAK     = 16'h203B;
	localparam logic [15:0] IDX_ENC      = 16'h2059;
	localparam logic [15:0] IDX_SUBMODE  = 16'h3202;
	localparam logic [15:0] IDX_CTRL     = 16'h6040;
	localparam logic [15:0] IDX_STAT     = 16'h6041;
	localparam logic [15:0] IDX_MODE     = 16'h6060;
	localparam logic [15:0] IDX_RES_BASE = 16'h3240;

	// ==========================================================
	// Field positions and codes
	localparam logic [7:0]  MODE_AUTOSETUP = 8'hFE;
	localparam int          CW_MODE_BIT    = 4;
	localparam int          SW_DONE_BIT    = 12;
	localparam int          SW_IDX_BIT     = 10;
	localparam int          SW_OPEN_BIT    = 2;
	localparam int          SUB_CL_BIT     = 0;
	localparam int          SUB_BRAKE_BIT  = 2;
	localparam int          SUB_BLDC_BIT   = 6;
	localparam logic [31:0] SUB_BLDC       = 32'h0000_0041;
	localparam logic [31:0] SUB_STEP_BRAKE = 32'h0000_0004;
	localparam logic [31:0] SUB_BLDC_BRAKE = 32'h0000_0044;
	localparam logic [31:0] ENC_DIFF_5V    = 32'h0000_0000;
	localparam logic [31:0] ENC_SINGLE_5V  = 32'h0000_0002;
	localparam logic [31:0] RST_WORD       = 32'h0000_0000;
	localparam logic [15:0] RST_HALF       = 16'h0000;
	localparam logic [7:0]  RST_BYTE       = 8'h00;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int STEP_TIME_NS  = 100000;
	localparam int STEP_CYCLES   =
		(STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] STEP_LOAD = 12'(STEP_CYCLES - 1);
	localparam logic [3:0]  LATE_LOAD = 4'h7;
	localparam int          NUM_RESULTS = 7;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		STEP_TYPE  = 3'h0,
		STEP_RES   = 3'h1,
		STEP_IND   = 3'h2,
		STEP_FLUX  = 3'h3,
		STEP_ENC   = 3'h4,
		STEP_ALIGN = 3'h5,
		STEP_HALL  = 3'h6
	} mas_step_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        crcOk;
		logic [15:0] index;
		logic [31:0] data;
	} mas_req_t;

	typedef struct packed {
		logic        valid;
		logic        err;
		logic [31:0] data;
	} mas_resp_t;

endpackage : mas_pkg

// ===== rtl/mas_meas_unit.sv
// Purpose: Runs one timed measurement step and watches index and limit pins.
// Assumes: measIn comes from converter logic on the same clock.
// Notes:   Pins pass three flip-flops; a level counts once stages agree.

`timescale 1ns/1ps
`default_nettype none

module mas_meas_unit
	import mas_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        go,
	input  wire mas_step_t   step,
	input  wire logic        clrIdx,
	input  wire logic [31:0] measIn,
	input  wire logic        idxPin,
	input  wire logic        limitPin,
	output logic             done,
	output logic [31:0]      value,
	output logic             idxSeen,
	output logic             limitHit
);

	// ==========================================================
	// Pin synchronisers
	logic [2:0] idxSync_reg;
	logic [2:0] limSync_reg;
	logic       idxLvl_reg, idxLvl_next;
	logic       limLvl_reg, limLvl_next;

	always_comb begin
		idxLvl_next = idxLvl_reg;
		limLvl_next = limLvl_reg;
		if (idxSync_reg[1] == idxSync_reg[2]) begin
			idxLvl_next = idxSync_reg[2];
		end
		if (limSync_reg[1] == limSync_reg[2]) begin
			limLvl_next = limSync_reg[2];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			idxSync_reg <= 3'h0;
			limSync_reg <= 3'h0;
			idxLvl_reg  <= 1'b0;
			limLvl_reg  <= 1'b0;
		end else begin
			idxSync_reg <= {idxSync_reg[1:0], idxPin};
			limSync_reg <= {limSync_reg[1:0], limitPin};
			idxLvl_reg  <= idxLvl_next;
			limLvl_reg  <= limLvl_next;
		end
	end

	assign limitHit = limLvl_reg;

	// ==========================================================
	// Step timer
	logic        busy_reg, busy_next;
	logic [11:0] cnt_reg, cnt_next;
	logic        done_reg, done_next;
	logic [31:0] value_reg, value_next;
	logic        seen_reg, seen_next;

	always_comb begin
		busy_next  = busy_reg;
		cnt_next   = cnt_reg;
		done_next  = 1'b0;
		value_next = value_reg;
		seen_next  = seen_reg;
		if (go) begin
			busy_next = 1'b1;
			cnt_next  = STEP_LOAD;
		end else if (busy_reg && cnt_reg == 12'h000) begin
			busy_next  = 1'b0;
			done_next  = 1'b1;
			value_next = measIn;
		end else if (busy_reg) begin
			cnt_next = cnt_reg - 12'h001;
		end
		// Index pulses only count inside the alignment run.
		if (busy_reg && step == STEP_ALIGN && idxLvl_next && !idxLvl_reg) begin
			seen_next = 1'b1;
		end else if (clrIdx) begin
			seen_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			busy_reg  <= 1'b0;
			cnt_reg   <= 12'h000;
			done_reg  <= 1'b0;
			value_reg <= RST_WORD;
			seen_reg  <= 1'b0;
		end else begin
			busy_reg  <= busy_next;
			cnt_reg   <= cnt_next;
			done_reg  <= done_next;
			value_reg <= value_next;
			seen_reg  <= seen_next;
		end
	end

	assign done    = done_reg;
	assign value   = value_reg;
	assign idxSeen = seen_reg;

endmodule : mas_meas_unit

`default_nettype wire

// ===== rtl/mas_step_seq.sv
// Purpose: Orders the auto-setup measurement steps one after another.
// Assumes: Fitment flags are stable while a run is in progress.
// Notes:   An abort drops back to idle without a finish pulse.

`timescale 1ns/1ps
`default_nettype none

module mas_step_seq
	import mas_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      reset,
	input  wire logic      start,
	input  wire logic      abort,
	input  wire logic      encIdx,
	input  wire logic      hall,
	input  wire logic      stepDone,
	output logic           stepGo,
	output mas_step_t      step,
	output logic           running,
	output logic           finish
);

	// ==========================================================
	// Step order
	// Returns {last, next step}; optional steps are skipped.
	function automatic logic [3:0] nextStep(input mas_step_t cur,
		input logic e, input logic h);
		logic [3:0] r;
		r = 4'h8;
		case (cur)
			STEP_TYPE:  r = {1'b0, STEP_RES};
			STEP_RES:   r = {1'b0, STEP_IND};
			STEP_IND:   r = {1'b0, STEP_FLUX};
			STEP_FLUX:  r = e ? {1'b0, STEP_ENC} :
				(h ? {1'b0, STEP_HALL} : 4'h8);
			STEP_ENC:   r = {1'b0, STEP_ALIGN};
			STEP_ALIGN: r = h ? {1'b0, STEP_HALL} : 4'h8;
			default:    r = 4'h8;
		endcase
		return r;
	endfunction : nextStep

	typedef enum logic [3:0] {
		SQ_IDLE  = 4'h1,
		SQ_ISSUE = 4'h2,
		SQ_WAIT  = 4'h4,
		SQ_END   = 4'h8
	} mas_seq_t;

	// ==========================================================
	// State machine
	mas_seq_t   state_reg, state_next;
	mas_step_t  step_reg, step_next;
	logic       go_reg, go_next;
	logic       fin_reg, fin_next;
	logic [3:0] nx;

	always_comb begin
		state_next = state_reg;
		step_next  = step_reg;
		go_next    = 1'b0;
		fin_next   = 1'b0;
		nx         = nextStep(step_reg, encIdx, hall);
		case (state_reg)
			SQ_IDLE: begin
				if (start) begin
					step_next  = STEP_TYPE;
					state_next = SQ_ISSUE;
				end
			end
			SQ_ISSUE: begin
				go_next    = 1'b1;
				state_next = SQ_WAIT;
			end
			SQ_WAIT: begin
				// One step must end before the next is issued.
				if (stepDone && nx[3]) begin
					state_next = SQ_END;
				end else if (stepDone) begin
					step_next  = mas_step_t'(nx[2:0]);
					state_next = SQ_ISSUE;
				end
			end
			SQ_END: begin
				fin_next   = 1'b1;
				state_next = SQ_IDLE;
			end
			default: state_next = SQ_IDLE;
		endcase
		if (abort && state_reg != SQ_IDLE) begin
			state_next = SQ_IDLE;
			go_next    = 1'b0;
			fin_next   = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= SQ_IDLE;
			step_reg  <= STEP_TYPE;
			go_reg    <= 1'b0;
			fin_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			step_reg  <= step_next;
			go_reg    <= go_next;
			fin_reg   <= fin_next;
		end
	end

	assign stepGo  = go_reg;
	assign step    = step_reg;
	assign running = (state_reg != SQ_IDLE);
	assign finish  = fin_reg;

endmodule : mas_step_seq

`default_nettype wire

// ===== rtl/mas_auto_setup.sv
// Purpose: Motor-data objects and the auto-setup run of a motor controller.
// Assumes: Messages arrive already deframed from the serial link.
// Notes:   Object access is by index; subindices are not decoded.
//
// Contract
// - Mode object value FE selects the auto-setup mode.
// - Rising control word bit 4 starts a run in mode, when enabled.
// - Status bit 12 goes high once the whole run has ended.
// - Status bit 10 shows whether an encoder index was found.
// - Every run measures type, resistance, inductance and flux.
// - Encoder resolution and alignment only with encoder and index.
// - Hall transitions measured only when a Hall sensor is fitted.
// - Success writes results into objects and stores drive, tuning.
// - Closed loop allowed only after a successful run.
// - Limit switches stay active while the run is going.
// - Coordinates are invalid after a run; host restarts the device.
// - Answers may come late while a run is going.
// - Submode 00000041h means brushless, brake control off.
// - Brake on: 00000004h stepper, 00000044h brushless.
// - Encoder 00000000h is 5 V differential, 00000002h single-ended.
// - No valid answer content before the first correct message.

`timescale 1ns/1ps
`default_nettype none

module mas_auto_setup
	import mas_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire mas_req_t    req,
	input  wire logic        opEnabled,
	input  wire logic        encFitted,
	input  wire logic        idxFitted,
	input  wire logic        hallFitted,
	input  wire logic [31:0] measIn,
	input  wire logic        idxPin,
	input  wire logic        limitPin,
	output mas_resp_t        resp,
	output logic             closedLoopOk,
	output logic             coordValid,
	output logic             setupActive,
	output logic             storeDrive,
	output logic             storeTuning
);

	// ==========================================================
	// Submodules
	logic        seqStart, seqAbort, stepGo, running, finish;
	logic        measDone, idxSeen, limitHit;
	logic [31:0] measVal;
	mas_step_t   step;

	mas_step_seq uSeq (
		.clk      (clk),
		.reset    (reset),
		.start    (seqStart),
		.abort    (seqAbort),
		.encIdx   (encFitted & idxFitted),
		.hall     (hallFitted),
		.stepDone (measDone),
		.stepGo   (stepGo),
		.step     (step),
		.running  (running),
		.finish   (finish)
	);

	mas_meas_unit uMeas (
		.clk      (clk),
		.reset    (reset),
		.go       (stepGo),
		.step     (step),
		.clrIdx   (seqStart),
		.measIn   (measIn),
		.idxPin   (idxPin),
		.limitPin (limitPin),
		.done     (measDone),
		.value    (measVal),
		.idxSeen  (idxSeen),
		.limitHit (limitHit)
	);

	// ==========================================================
	// Decode helpers
	function automatic logic isObj(input logic [15:0] a,
		input logic [15:0] b);
		return a == b;
	endfunction : isObj

	function automatic logic isRes(input logic [15:0] a);
		return a >= IDX_RES_BASE &&
			a < IDX_RES_BASE + 16'(NUM_RESULTS);
	endfunction : isRes

	// ==========================================================
	// Object registers and message handling
	logic [31:0] pole_reg, pole_next;
	logic [31:0] curr_reg, curr_next;
	logic [31:0] peak_reg, peak_next;
	logic [31:0] enc_reg, enc_next;
	logic [31:0] sub_reg, sub_next;
	logic [15:0] ctrl_reg, ctrl_next;
	logic [7:0]  mode_reg, mode_next;
	logic        init_reg, init_next;
	logic        done_reg, done_next;
	logic        idxF_reg, idxF_next;
	logic        ok_reg, ok_next;
	logic        coord_reg, coord_next;
	logic        stD_reg, stD_next;
	logic        stT_reg, stT_next;
	logic        pend_reg, pend_next;
	logic [3:0]  late_reg, late_next;
	logic        hErr_reg, hErr_next;
	logic [31:0] hData_reg, hData_next;
	mas_resp_t   resp_reg, resp_next;
	logic [31:0] resMem [NUM_RESULTS];
	logic [15:0] statusWord;
	logic        take, modeSel;
	logic [31:0] rd;
	logic        rdErr;
	logic [2:0]  resIdx;

	assign modeSel = (mode_reg == MODE_AUTOSETUP);
	// Word bits 12 and 10 are only meaningful after a run.
	assign statusWord = (16'h0001 << SW_DONE_BIT) & {16{done_reg}} |
		(16'h0001 << SW_IDX_BIT) & {16{idxF_reg}} |
		(16'h0001 << SW_OPEN_BIT) & {16{opEnabled}};
	assign take   = req.valid && req.crcOk && !pend_reg;
	assign resIdx = 3'(req.index - IDX_RES_BASE);

	always_comb begin
		rd    = RST_WORD;
		rdErr = 1'b0;
		if (isObj(req.index, IDX_POLE)) begin
			rd = pole_reg;
		end else if (isObj(req.index, IDX_CURR)) begin
			rd = curr_reg;
		end else if (isObj(req.index, IDX_PEAK)) begin
			rd = peak_reg;
		end else if (isObj(req.index, IDX_ENC)) begin
			rd = enc_reg;
		end else if (isObj(req.index, IDX_SUBMODE)) begin
			rd = sub_reg;
		end else if (isObj(req.index, IDX_CTRL)) begin
			rd = {16'h0000, ctrl_reg};
		end else if (isObj(req.index, IDX_STAT)) begin
			rd = {16'h0000, statusWord};
		end else if (isObj(req.index, IDX_MODE)) begin
			rd = {24'h00_0000, mode_reg};
		end else if (isRes(req.index)) begin
			rd = resMem[resIdx];
		end else begin
			rdErr = 1'b1;
		end
	end

	always_comb begin
		pole_next  = pole_reg;
		curr_next  = curr_reg;
		peak_next  = peak_reg;
		enc_next   = enc_reg;
		sub_next   = sub_reg;
		ctrl_next  = ctrl_reg;
		mode_next  = mode_reg;
		init_next  = init_reg;
		done_next  = done_reg;
		idxF_next  = idxF_reg;
		ok_next    = ok_reg;
		coord_next = coord_reg;
		stD_next   = 1'b0;
		stT_next   = 1'b0;
		pend_next  = pend_reg;
		late_next  = late_reg;
		hErr_next  = hErr_reg;
		hData_next = hData_reg;
		resp_next  = '0;
		seqStart   = 1'b0;
		// Opening the limit switch or losing enable ends the run.
		seqAbort   = running && (limitHit || !opEnabled || !modeSel);
		if (take) begin
			init_next  = 1'b1;
			pend_next  = 1'b1;
			// While busy the answer waits a few cycles.
			late_next  = running ? LATE_LOAD : 4'h0;
			hErr_next  = rdErr;
			// Content stays blank until a correct message arrived.
			hData_next = (req.write || !init_reg) ? RST_WORD : rd;
			if (req.write) begin
				if (isObj(req.index, IDX_POLE)) begin
					pole_next = req.data;
				end else if (isObj(req.index, IDX_CURR)) begin
					curr_next = req.data;
				end else if (isObj(req.index, IDX_PEAK)) begin
					peak_next = req.data;
				end else if (isObj(req.index, IDX_ENC)) begin
					enc_next = req.data;
				end else if (isObj(req.index, IDX_SUBMODE)) begin
					sub_next = req.data;
				end else if (isObj(req.index, IDX_CTRL)) begin
					ctrl_next = req.data[15:0];
					if (req.data[CW_MODE_BIT] && !ctrl_reg[CW_MODE_BIT] &&
						modeSel && opEnabled && !running) begin
						seqStart  = 1'b1;
						done_next = 1'b0;
						ok_next   = 1'b0;
					end
				end else if (isObj(req.index, IDX_MODE)) begin
					mode_next = req.data[7:0];
				end else begin
					hErr_next = 1'b1;
				end
			end
		end
		if (pend_reg && late_reg == 4'h0) begin
			pend_next = 1'b0;
			resp_next = '{valid: 1'b1, err: hErr_reg, data: hData_reg};
		end else if (pend_reg) begin
			late_next = late_reg - 4'h1;
		end
		if (seqStart || running) begin
			coord_next = 1'b0;
		end
		if (finish) begin
			done_next = 1'b1;
			idxF_next = idxSeen;
			ok_next   = 1'b1;
			// Motor type found in the first step replaces the brushless bit.
			sub_next[SUB_BLDC_BIT] = resMem[STEP_TYPE][0];
			stD_next  = 1'b1;
			stT_next  = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pole_reg  <= RST_WORD;
			curr_reg  <= RST_WORD;
			peak_reg  <= RST_WORD;
			enc_reg   <= RST_WORD;
			sub_reg   <= RST_WORD;
			ctrl_reg  <= RST_HALF;
			mode_reg  <= RST_BYTE;
			init_reg  <= 1'b0;
			done_reg  <= 1'b0;
			idxF_reg  <= 1'b0;
			ok_reg    <= 1'b0;
			coord_reg <= 1'b1;
			stD_reg   <= 1'b0;
			stT_reg   <= 1'b0;
			pend_reg  <= 1'b0;
			late_reg  <= 4'h0;
			hErr_reg  <= 1'b0;
			hData_reg <= RST_WORD;
			resp_reg  <= '0;
		end else begin
			pole_reg  <= pole_next;
			curr_reg  <= curr_next;
			peak_reg  <= peak_next;
			enc_reg   <= enc_next;
			sub_reg   <= sub_next;
			ctrl_reg  <= ctrl_next;
			mode_reg  <= mode_next;
			init_reg  <= init_next;
			done_reg  <= done_next;
			idxF_reg  <= idxF_next;
			ok_reg    <= ok_next;
			coord_reg <= coord_next;
			stD_reg   <= stD_next;
			stT_reg   <= stT_next;
			pend_reg  <= pend_next;
			late_reg  <= late_next;
			hErr_reg  <= hErr_next;
			hData_reg <= hData_next;
			resp_reg  <= resp_next;
		end
	end

	// ==========================================================
	// Measurement results
	// Results are kept without reset; they are only trusted after a run.
	always_ff @(posedge clk) begin
		if (measDone) begin
			resMem[step] <= measVal;
		end
	end

	// ==========================================================
	// Outputs
	logic clOk_reg, clOk_next;
	logic act_reg, act_next;

	always_comb begin
		// Closed loop needs the mode bit and a finished run.
		clOk_next = sub_next[SUB_CL_BIT] && ok_next;
		act_next  = running && !seqAbort;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			clOk_reg <= 1'b0;
			act_reg  <= 1'b0;
		end else begin
			clOk_reg <= clOk_next;
			act_reg  <= act_next;
		end
	end

	assign resp         = resp_reg;
	assign closedLoopOk = clOk_reg;
	assign coordValid   = coord_reg;
	assign setupActive  = act_reg;
	assign storeDrive   = stD_reg;
	assign storeTuning  = stT_reg;

endmodule : mas_auto_setup

`default_nettype wire

// ===== tb/mas_auto_setup_sva.sv
// Purpose: Port assertions for the auto-setup block.
// Assumes: The host never sends while an answer is pending.
// Notes:   Bound to every instance of the top module.

`timescale 1ns/1ps
`default_nettype none

module mas_auto_setup_sva
	import mas_pkg::*;
(
	input wire logic        clk,
	input wire logic        reset,
	input wire mas_req_t    req,
	input wire logic        opEnabled,
	input wire logic        encFitted,
	input wire logic        idxFitted,
	input wire logic        hallFitted,
	input wire logic [31:0] measIn,
	input wire logic        idxPin,
	input wire logic        limitPin,
	input wire mas_resp_t   resp,
	input wire logic        closedLoopOk,
	input wire logic        coordValid,
	input wire logic        setupActive,
	input wire logic        storeDrive,
	input wire logic        storeTuning
);
	// ==========================================================
	// Helper state
	localparam int MIN_RUN = 16000;
	logic [15:0] runCnt_reg;
	logic [15:0] runCnt_next;
	logic        doneSeen_reg;
	logic        doneSeen_next;

	// A count left over by an aborted run only makes the length check
	// more lenient, never falsely strict.
	always_comb begin
		runCnt_next = runCnt_reg;
		if (storeDrive) begin
			runCnt_next = 16'h0000;
		end else if (setupActive) begin
			runCnt_next = runCnt_reg + 16'h0001;
		end
		doneSeen_next = doneSeen_reg | storeDrive;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			runCnt_reg   <= 16'h0000;
			doneSeen_reg <= 1'b0;
		end else begin
			runCnt_reg   <= runCnt_next;
			doneSeen_reg <= doneSeen_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ==========================================================
	// Assertions
	AST_IDLE_ANSWER: assert property (
		(req.valid && req.crcOk && !setupActive &&
		!(req.write && req.index == IDX_CTRL)) |-> ##1 !resp.valid ##1 resp.valid)
		else $error("idle answer not two cycles after the request");
	AST_BADCRC_SILENT: assert property (
		(req.valid && !req.crcOk && !setupActive) |-> ##2 !resp.valid)
		else $error("answer given to a corrupt message");
	AST_BUSY_LATE: assert property (
		(req.valid && req.crcOk && setupActive) ##1 setupActive[*8]
		|=> resp.valid)
		else $error("busy answer not nine cycles after the request");
	AST_RESP_PULSE: assert property (
		resp.valid |=> !resp.valid)
		else $error("answer stood longer than one cycle");
	AST_STORE_PAIR: assert property (
		storeDrive |-> storeTuning && !setupActive)
		else $error("drive store without tuning store");
	AST_STORE_PULSE: assert property (
		storeDrive |=> !storeDrive && !storeTuning)
		else $error("store request longer than one cycle");
	AST_RUN_LENGTH: assert property (
		storeDrive |-> runCnt_reg >= MIN_RUN)
		else $error("run finished before four full steps");
	AST_COORD_HOLD: assert property (
		(!coordValid || setupActive) |=> !coordValid)
		else $error("coordinates valid again without reset");
	AST_CLOSED_LOOP: assert property (
		closedLoopOk |-> (doneSeen_reg || storeDrive))
		else $error("closed loop allowed without a finished run");
	AST_LIMIT_ABORT: assert property (
		(setupActive && limitPin)[*4] |-> ##[0:6] !setupActive)
		else $error("limit switch did not stop the run");
endmodule : mas_auto_setup_sva

bind mas_auto_setup mas_auto_setup_sva mas_auto_setup_sva_inst (
	.clk, .reset, .req, .opEnabled, .encFitted, .idxFitted, .hallFitted,
	.measIn, .idxPin, .limitPin, .resp, .closedLoopOk, .coordValid,
	.setupActive, .storeDrive, .storeTuning
);

`default_nettype wire

// ===== tb/mas_host_model.sv
// Purpose: Host side of the object bus: one message, one bounded wait.
// Assumes: Requests change at the falling edge only.
// Notes:   Between messages the idle fields show the inverse of the last.

`timescale 1ns/1ps
`default_nettype none

module mas_host_model
	import mas_pkg::*;
(
	input  wire logic      clk,
	input  wire mas_resp_t resp,
	output mas_req_t       req
);
	initial req = '0;

	// ==========================================================
	// Access task; the host waits out late answers.
	task automatic access(
		input  logic        wr,
		input  logic        crc,
		input  logic [15:0] idx,
		input  logic [31:0] dat,
		output logic [31:0] rd,
		output logic        er,
		output logic        ok
	);
		int n;
		ok = 1'b0;
		rd = 32'h0000_0000;
		er = 1'b0;
		@(negedge clk);
		req <= '{valid:1'b1, write:wr, crcOk:crc, index:idx, data:dat};
		@(negedge clk);
		req <= '{valid:1'b0, write:~wr, crcOk:~crc, index:~idx, data:~dat};
		for (n = 0; n < 20 && !ok; n++) begin
			@(negedge clk);
			if (resp.valid === 1'b1) begin
				ok = 1'b1;
				rd = resp.data;
				er = resp.err;
			end
		end
	endtask : access

	// The host keeps user programs stopped; none exist here.
endmodule : mas_host_model

`default_nettype wire

// ===== tb/test_mas_auto_setup.sv
// Purpose: Self-checking bench for the auto-setup block.
// Assumes: Host model drives the object bus at the falling edge.
// Notes:   Two full runs and one aborted run; about 45k cycles.

`timescale 1ns/1ps
`default_nettype none

module test_mas_auto_setup;
	import mas_pkg::*;
	logic clk = 1'b0, reset = 1'b1, opEnabled = 1'b0, encFitted = 1'b0;
	logic idxFitted = 1'b0, hallFitted = 1'b0, idxPin = 1'b0;
	logic limitPin = 1'b0, closedLoopOk, coordValid, setupActive;
	logic storeDrive, storeTuning;
	logic [31:0] measIn = 32'h0000_0000;
	mas_req_t req;
	mas_resp_t resp;
	int err_count = 0, checks = 0, runLen = 0, storeCnt = 0, tuneCnt = 0;

	mas_auto_setup mas_auto_setup_inst (.clk, .reset, .req, .opEnabled,
		.encFitted, .idxFitted, .hallFitted, .measIn, .idxPin, .limitPin,
		.resp, .closedLoopOk, .coordValid, .setupActive, .storeDrive,
		.storeTuning);
	mas_host_model mas_host_model_inst (.clk, .resp, .req);

	initial forever #12.5 clk = ~clk;
	initial forever begin
		repeat (90) @(negedge clk);
		idxPin <= 1'b1;
		repeat (6) @(negedge clk);
		idxPin <= 1'b0;
	end
	always @(posedge clk) begin
		runLen <= runLen + int'(setupActive === 1'b1);
		storeCnt <= storeCnt + int'(storeDrive === 1'b1);
		tuneCnt <= tuneCnt + int'(storeTuning === 1'b1);
	end

	// ==========================================================
	// Shared tasks
	task automatic final_report;
		if (err_count == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic acc(input logic wr, input logic [15:0] idx,
		input logic [31:0] dat, output logic [31:0] rd, output logic er);
		logic ok;
		mas_host_model_inst.access(wr, 1'b1, idx, dat, rd, er, ok);
		if (ok !== 1'b1) begin
			err_count++;
			final_report();
		end
	endtask : acc

	task automatic wrObj(input logic [15:0] idx, input logic [31:0] dat);
		logic [31:0] rd;
		logic er;
		acc(1'b1, idx, dat, rd, er);
	endtask : wrObj

	task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] rd;
		logic er;
		acc(1'b0, idx, 32'h0000_0000, rd, er);
		check(rd, exp);
	endtask : rdChk

	task automatic startRun;
		wrObj(IDX_MODE, 32'h0000_00FE);
		opEnabled <= 1'b1;
		wrObj(IDX_CTRL, 32'h0000_0000);
		runLen = 0;
		storeCnt = 0;
		tuneCnt = 0;
		wrObj(IDX_CTRL, 32'h0000_0010);
	endtask : startRun

	// ==========================================================
	// Scenarios
	task automatic t_boot;
		logic [31:0] rd;
		logic er, ok;
		opEnabled <= 1'b1;
		check({31'h0, coordValid}, 32'h0000_0001);
		mas_host_model_inst.access(1'b1, 1'b0, IDX_POLE, 32'h0000_0032, rd,
			er, ok);
		check({31'h0, ok}, 32'h0000_0000);
		// The status word is not zero here, so a blank first answer shows.
		rdChk(IDX_STAT, 32'h0000_0000);
		rdChk(IDX_STAT, 32'h0000_0004);
		rdChk(IDX_POLE, 32'h0000_0000);
		wrObj(IDX_POLE, 32'h0000_0032);
		rdChk(IDX_POLE, 32'h0000_0032);
	endtask : t_boot

	task automatic t_objects;
		logic [15:0] ix[8] = '{IDX_CURR, IDX_PEAK, IDX_ENC, IDX_SUBMODE,
			IDX_SUBMODE, IDX_ENC, IDX_MODE, IDX_SUBMODE};
		logic [31:0] vl[8] = '{32'h0000_04B0, 32'h0000_0064, ENC_SINGLE_5V,
			SUB_STEP_BRAKE, SUB_BLDC, ENC_DIFF_5V, 32'h0000_00FE,
			SUB_BLDC_BRAKE};
		logic [31:0] rd;
		logic er;
		foreach (ix[i]) begin
			wrObj(ix[i], vl[i]);
			rdChk(ix[i], vl[i]);
		end
		acc(1'b1, IDX_STAT, 32'h0000_1000, rd, er);
		check({31'h0, er}, 32'h0000_0001);
		acc(1'b0, 16'h1234, 32'h0000_0000, rd, er);
		check({31'h0, er}, 32'h0000_0001);
		// Closed loop is asked for but no run has finished yet.
		wrObj(IDX_SUBMODE, 32'h0000_0001);
		check({31'h0, closedLoopOk}, 32'h0000_0000);
	endtask : t_objects

	task automatic t_abort;
		startRun();
		repeat (100) @(negedge clk);
		limitPin <= 1'b1;
		repeat (20) @(negedge clk);
		limitPin <= 1'b0;
		check({31'h0, setupActive}, 32'h0000_0000);
		check(storeCnt, 32'h0000_0000);
		rdChk(IDX_STAT, 32'h0000_0004);
	endtask : t_abort

	task automatic t_run(input logic e, input logic h, input logic [31:0] m,
		input logic [31:0] sub, input logic [31:0] subExp);
		logic [31:0] st;
		int n, steps;
		steps = 4 + (e ? 2 : 0) + (h ? 1 : 0);
		encFitted <= e;
		idxFitted <= e;
		hallFitted <= h;
		measIn <= m;
		wrObj(IDX_SUBMODE, sub);
		startRun();
		rdChk(IDX_STAT, 32'h0000_0004);
		st = 32'h0000_0000;
		for (n = 0; n < 80 && !st[12]; n++) begin
			repeat (500) @(negedge clk);
			acc(1'b0, IDX_STAT, 32'h0000_0000, st, st[0]);
		end
		if (!st[12]) begin
			err_count++;
			final_report();
		end
		check(st, {19'h0, 1'b1, 1'b0, e, 7'h0, 3'h4});
		check(runLen / 4000, steps);
		check({storeCnt[15:0], tuneCnt[15:0]}, 32'h0001_0001);
		for (n = 0; n < 4; n++) begin
			rdChk(IDX_RES_BASE + 16'(n), m);
		end
		rdChk(e ? IDX_RES_BASE + 16'h0004 : IDX_RES_BASE + 16'h0006, m);
		rdChk(IDX_SUBMODE, subExp);
		check({30'h0, coordValid, closedLoopOk}, {31'h0, sub[0]});
	endtask : t_run

	initial begin
		repeat (12) @(negedge clk);
		reset <= 1'b0;
		t_boot();
		t_objects();
		t_abort();
		t_run(1'b0, 1'b1, 32'h0000_1230, SUB_BLDC_BRAKE, SUB_STEP_BRAKE);
		t_run(1'b1, 1'b0, 32'h0000_4561, 32'h0000_0001, SUB_BLDC);
		final_report();
	end
endmodule : test_mas_auto_setup

`default_nettype wire
